// ===== logic/pdg_pkg.sv
// constants and types shared by the pwm duty/period generator
// Contract
// RULE1 - period is (limit+1) x 4 x prescale clocks
// RULE2 - limit match: clear timer, latch duty, set
// RULE3 - duty beyond period leaves the output unchanged
// RULE4 - ten-bit left-justified duty in high/low bytes
// RULE5 - duty buffered, takes effect at period end
// RULE6 - time base is timer plus two bits
// RULE7 - clock phase at 1:1, else prescaler bits
// RULE8 - high time is duty x clock x prescale
// RULE9 - ten-bit resolution at limit 255
// RULE10 - sleep freezes timer, state and output
// RULE11 - wake resumes timer where it stopped
// RULE12 - all timing derived from system clock
// RULE13 - output falls when time base meets duty
// RULE14 - reset clears state, output low until enabled
package pdg_pkg;

  // ----------------------------------------------------------------
  // register map, byte addresses on the ahb-lite port
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PERIOD_LIMIT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DUTY_HIGH = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DUTY_LOW = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;

  // ----------------------------------------------------------------
  // field layout and widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int TMR_W = 8;       // period_timer width
  localparam int DUTY_W = 10;     // duty_value width
  localparam int PRE_W = 8;       // prescaler counter, up to 64 x 4
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PSEL_LSB = 1;
  localparam int DUTY_LOW_LSB = 6;  // duty_low<7:6> hold the two lsbs
  localparam int ST_TMR_LSB = 0;
  localparam int ST_LOW_LSB = 8;
  localparam int ST_DUTY_LSB = 10;
  localparam int ST_OUT_BIT = 20;
  localparam int ST_SLEEP_BIT = 21;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [TMR_W-1:0] PERIOD_LIMIT_RST = 8'hFF;
  localparam logic [DUTY_W-1:0] DUTY_RST = 10'h000;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // prescale select and prescaler terminal counts (4 x factor - 1)
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PDG_PS_1 = 2'b00,
    PDG_PS_4 = 2'b01,
    PDG_PS_16 = 2'b10,
    PDG_PS_64 = 2'b11
  } pdg_psel_t;
  localparam logic [PRE_W-1:0] TERM_PS_1 = 8'h03;
  localparam logic [PRE_W-1:0] TERM_PS_4 = 8'h0F;
  localparam logic [PRE_W-1:0] TERM_PS_16 = 8'h3F;
  localparam logic [PRE_W-1:0] TERM_PS_64 = 8'hFF;

  // ahb-lite transfer type bit that marks an active transfer
  localparam int HTRANS_ACTIVE_BIT = 1;

endpackage : pdg_pkg

// ===== logic/pdg_prescaler.sv
// system-clock phase counter and timer prescaler
module pdg_prescaler (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic clear_i,
  input wire pdg_pkg::pdg_psel_t psel_i,
  output logic tick_o,
  output logic [1:0] low_next_o
);

  // ----------------------------------------------------------------
  // counter and terminal count
  // ----------------------------------------------------------------
  logic [pdg_pkg::PRE_W-1:0] cnt_reg;  // clocks within one timer step
  logic [pdg_pkg::PRE_W-1:0] cnt_next;
  logic [pdg_pkg::PRE_W-1:0] term;     // last count of a timer step

  // terminal count per prescale factor
  always_comb begin
    case (psel_i)
      pdg_pkg::PDG_PS_1: term = pdg_pkg::TERM_PS_1;
      pdg_pkg::PDG_PS_4: term = pdg_pkg::TERM_PS_4;
      pdg_pkg::PDG_PS_16: term = pdg_pkg::TERM_PS_16;
      default: term = pdg_pkg::TERM_PS_64;
    endcase
  end

  // >= so a prescale change mid-step cannot run past the terminal
  assign tick_o = run_i && (cnt_reg >= term);

  // next count, held while not running
  always_comb begin
    if (!run_i) begin
      cnt_next = cnt_reg;
    end else if (tick_o) begin
      cnt_next = '0;
    end else begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  // RULE7 phase or prescaler
  // at 1:1 the two lsbs are the clock phase, else the two
  // prescaler bits just above the divide-by factor
  assign low_next_o = 2'(cnt_next >> {psel_i, 1'b0});

  // counter register, cleared while the block is disabled
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule : pdg_prescaler

// ===== logic/pdg_sync2.sv
// two-flop synchroniser for one level from outside the clock domain
module pdg_sync2 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);

  // ----------------------------------------------------------------
  // synchroniser chain
  // ----------------------------------------------------------------
  logic meta_reg;  // first stage, read only by the second stage

  // both stages reset to the idle level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end

endmodule : pdg_sync2

// ===== logic/pdg_top.sv
// pwm duty/period generator with ahb-lite register port
module pdg_top (
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic HSEL_I,
  input wire logic [pdg_pkg::ADDR_W-1:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [pdg_pkg::DATA_W-1:0] HWDATA_I,
  input wire logic HREADY_I,
  input wire logic SLEEP_I,
  output logic [pdg_pkg::DATA_W-1:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  output logic WAVEFORM_OUTPUT_O
);

  // ----------------------------------------------------------------
  // software-visible state
  // ----------------------------------------------------------------
  logic enable_reg;                              // modulator on
  pdg_pkg::pdg_psel_t psel_reg;                  // timer prescale
  logic [pdg_pkg::TMR_W-1:0] period_limit_reg;   // period limit
  logic [pdg_pkg::DUTY_W-1:0] duty_buf_reg;      // written duty
  logic [pdg_pkg::DUTY_W-1:0] duty_act_reg;      // latched duty

  // ----------------------------------------------------------------
  // time base state
  // ----------------------------------------------------------------
  logic [pdg_pkg::TMR_W-1:0] period_timer_reg;   // 8-bit timer
  logic [pdg_pkg::TMR_W-1:0] period_timer_next;
  logic [1:0] low_next;                          // time-base lsbs
  logic [1:0] low_reg;                           // for status reads
  logic [pdg_pkg::DUTY_W-1:0] tb_next;           // 10-bit time base
  logic [pdg_pkg::DUTY_W:0] period_len;          // 4 x (limit + 1)
  logic tick;                                    // timer step
  logic period_start;                            // limit reached
  logic sleep_s;                                 // synchronised sleep
  logic run;                                     // counting allowed
  logic out_reg;                                 // waveform level

  // ----------------------------------------------------------------
  // bus state
  // ----------------------------------------------------------------
  logic wr_pend_reg;                             // write data phase
  logic [pdg_pkg::ADDR_W-1:0] wr_addr_reg;       // its address
  logic [pdg_pkg::DATA_W-1:0] hrdata_reg;        // read answer
  logic [pdg_pkg::DATA_W-1:0] rd_word;           // decoded read
  logic hreadyout_reg;                           // never stalls
  logic hresp_reg;                               // always okay
  logic addr_valid;                              // accepted phase

  // ----------------------------------------------------------------
  // sleep request crosses from outside the clock domain
  // ----------------------------------------------------------------
  pdg_sync2 u_sleep_sync (
    .clk_i(CORE_CLK_I),
    .rst_i(SYS_RST_I),
    .d_i(SLEEP_I),
    .q_o(sleep_s)
  );

  // RULE10 sleep stops counting
  // a disabled or sleeping block does not advance
  assign run = enable_reg && !sleep_s;

  // ----------------------------------------------------------------
  // prescaler and phase counter
  // ----------------------------------------------------------------
  // RULE12 clock derived timing
  // every step of the time base is a count of core clocks, so the
  // output frequency follows the clock frequency exactly
  pdg_prescaler u_prescaler (
    .clk_i(CORE_CLK_I),
    .rst_i(SYS_RST_I),
    .run_i(run),
    .clear_i(!enable_reg),
    .psel_i(psel_reg),
    .tick_o(tick),
    .low_next_o(low_next)
  );

  // RULE2 limit match event
  assign period_start = tick && (period_timer_reg == period_limit_reg);

  // next timer value
  always_comb begin
    if (period_start) begin
      period_timer_next = '0;
    end else if (tick) begin
      period_timer_next = period_timer_reg + 1'b1;
    end else begin
      period_timer_next = period_timer_reg;
    end
  end

  // RULE6 ten-bit time base
  // the value the time base takes at the coming edge
  assign tb_next = {period_timer_next, low_next};

  // RULE9 resolution follows limit
  // one period spans 4 x (limit + 1) time-base steps, 1024 at 255
  assign period_len = {({1'b0, period_limit_reg} + 9'h001), 2'b00};

  // ----------------------------------------------------------------
  // period timer
  // ----------------------------------------------------------------
  // RULE11 resume after wake
  // timer holds through sleep and carries on from the same value
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I || !enable_reg) begin
      period_timer_reg <= '0;
      low_reg <= 2'b00;
    end else if (run) begin
      period_timer_reg <= period_timer_next;
      low_reg <= low_next;
    end
  end

  // ----------------------------------------------------------------
  // duty latch
  // ----------------------------------------------------------------
  // RULE5 glitch-free double buffer
  // the active duty only moves on a period boundary
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      duty_act_reg <= pdg_pkg::DUTY_RST;
    end else if (period_start) begin
      duty_act_reg <= duty_buf_reg;
    end
  end

  // ----------------------------------------------------------------
  // waveform output
  // ----------------------------------------------------------------
  // RULE8 high for duty steps
  // rises with the period and falls when the time base about to be
  // loaded equals the duty, giving duty x prescale clocks high
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      // RULE14 low out of reset
      out_reg <= 1'b0;
    end else if (!enable_reg) begin
      out_reg <= 1'b0;
    end else if (period_start) begin
      if (duty_buf_reg == '0) begin
        // RULE2 no pulse at zero
        out_reg <= 1'b0;
      end else if ({1'b0, duty_buf_reg} > period_len) begin
        // RULE3 overlong duty, hold
        out_reg <= out_reg;
      end else begin
        out_reg <= 1'b1;
      end
    end else if (run && (tb_next == duty_act_reg)) begin
      // RULE13 compare match clears
      out_reg <= 1'b0;
    end
  end

  assign WAVEFORM_OUTPUT_O = out_reg;

  // ----------------------------------------------------------------
  // ahb-lite address phase
  // ----------------------------------------------------------------
  assign addr_valid = HSEL_I && HREADY_I
    && HTRANS_I[pdg_pkg::HTRANS_ACTIVE_BIT];

  // read decode, unmapped words read as zero
  always_comb begin
    rd_word = pdg_pkg::WORD_ZERO;
    if (HADDR_I == pdg_pkg::OFS_CTRL) begin
      rd_word[pdg_pkg::CTRL_EN_BIT] = enable_reg;
      rd_word[pdg_pkg::CTRL_PSEL_LSB +: 2] = psel_reg;
    end else if (HADDR_I == pdg_pkg::OFS_PERIOD_LIMIT) begin
      rd_word[pdg_pkg::TMR_W-1:0] = period_limit_reg;
    end else if (HADDR_I == pdg_pkg::OFS_DUTY_HIGH) begin
      // RULE4 eight msbs
      rd_word[pdg_pkg::TMR_W-1:0] = duty_buf_reg[pdg_pkg::DUTY_W-1:2];
    end else if (HADDR_I == pdg_pkg::OFS_DUTY_LOW) begin
      // RULE4 two lsbs, left-justified
      rd_word[pdg_pkg::DUTY_LOW_LSB +: 2] = duty_buf_reg[1:0];
    end else if (HADDR_I == pdg_pkg::OFS_STATUS) begin
      rd_word[pdg_pkg::ST_TMR_LSB +: pdg_pkg::TMR_W] = period_timer_reg;
      rd_word[pdg_pkg::ST_LOW_LSB +: 2] = low_reg;
      rd_word[pdg_pkg::ST_DUTY_LSB +: pdg_pkg::DUTY_W] = duty_act_reg;
      rd_word[pdg_pkg::ST_OUT_BIT] = out_reg;
      rd_word[pdg_pkg::ST_SLEEP_BIT] = sleep_s;
    end
  end

  // capture write address, register read data for the data phase
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      hrdata_reg <= pdg_pkg::WORD_ZERO;
    end else begin
      wr_pend_reg <= addr_valid && HWRITE_I;
      if (addr_valid) begin
        wr_addr_reg <= HADDR_I;
      end
      if (addr_valid && !HWRITE_I) begin
        hrdata_reg <= rd_word;
      end
    end
  end

  // zero wait states and okay answers only
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end else begin
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end
  end

  assign HRDATA_O = hrdata_reg;
  assign HREADYOUT_O = hreadyout_reg;
  assign HRESP_O = hresp_reg;

  // ----------------------------------------------------------------
  // ahb-lite data phase writes
  // ----------------------------------------------------------------
  // control and period limit
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      enable_reg <= 1'b0;
      psel_reg <= pdg_pkg::PDG_PS_1;
      period_limit_reg <= pdg_pkg::PERIOD_LIMIT_RST;
    end else if (wr_pend_reg) begin
      if (wr_addr_reg == pdg_pkg::OFS_CTRL) begin
        enable_reg <= HWDATA_I[pdg_pkg::CTRL_EN_BIT];
        psel_reg <= pdg_pkg::pdg_psel_t'(
          HWDATA_I[pdg_pkg::CTRL_PSEL_LSB +: 2]);
      end else if (wr_addr_reg == pdg_pkg::OFS_PERIOD_LIMIT) begin
        // RULE1 software period limit
        period_limit_reg <= HWDATA_I[pdg_pkg::TMR_W-1:0];
      end
    end
  end

  // RULE5 writes land in buffer
  // accepted at any time, even mid-period; only the buffer changes
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      duty_buf_reg <= pdg_pkg::DUTY_RST;
    end else if (wr_pend_reg) begin
      if (wr_addr_reg == pdg_pkg::OFS_DUTY_HIGH) begin
        duty_buf_reg[pdg_pkg::DUTY_W-1:2] <=
          HWDATA_I[pdg_pkg::TMR_W-1:0];
      end else if (wr_addr_reg == pdg_pkg::OFS_DUTY_LOW) begin
        duty_buf_reg[1:0] <= HWDATA_I[pdg_pkg::DUTY_LOW_LSB +: 2];
      end
    end
  end

  // ----------------------------------------------------------------
  // checking helpers: clocks per period, trusted after a clean start
  // ----------------------------------------------------------------
  logic [11:0] chk_len_reg;      // running clocks since last period start
  logic chk_valid_reg;           // config unchanged since a start
  logic [11:0] chk_expect;       // expected clocks per period

  assign chk_expect = 12'(({4'h0, period_limit_reg} + 12'h001)
    << (2 + 2 * psel_reg));

  // counts only running clocks so sleep does not disturb it
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I || !enable_reg) begin
      chk_len_reg <= '0;
      chk_valid_reg <= 1'b0;
    end else begin
      if (period_start) begin
        chk_len_reg <= '0;
      end else if (run) begin
        chk_len_reg <= chk_len_reg + 1'b1;
      end
      if (wr_pend_reg && (wr_addr_reg == pdg_pkg::OFS_CTRL
          || wr_addr_reg == pdg_pkg::OFS_PERIOD_LIMIT)) begin
        chk_valid_reg <= 1'b0;
      end else if (period_start) begin
        chk_valid_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_period_len;  // RULE1
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
      (period_start && chk_valid_reg) |->
        (chk_len_reg == chk_expect - 12'h001);
  endproperty
  a_period_len: assert property (p_period_len)  // RULE1
    else $error("period length does not match limit and prescale");

  property p_wrap;  // RULE2
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
      (period_start && !wr_pend_reg) |=>
        (period_timer_reg == '0) && (duty_act_reg == $past(duty_buf_reg));
  endproperty
  a_wrap: assert property (p_wrap)  // RULE2
    else $error("timer not cleared or duty not latched at wrap");

  property p_rise;  // RULE2
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
      (period_start && enable_reg && duty_buf_reg != '0
        && {1'b0, duty_buf_reg} <= period_len) |=> WAVEFORM_OUTPUT_O;
  endproperty
  a_rise: assert property (p_rise)  // RULE2
    else $error("output not set at period start");

  property p_overlong;  // RULE3
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
      (period_start && {1'b0, duty_buf_reg} > period_len) |=>
        (WAVEFORM_OUTPUT_O == $past(WAVEFORM_OUTPUT_O));
  endproperty
  a_overlong: assert property (p_overlong)  // RULE3
    else $error("overlong duty changed the output");

  property p_duty_hold;  // RULE5
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
      !period_start |=> $stable(duty_act_reg);
  endproperty
  a_duty_hold: assert property (p_duty_hold)  // RULE5
    else $error("active duty changed away from a period boundary");

  property p_sleep_freeze;  // RULE10
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
      (sleep_s && enable_reg) [*2] |->
        $stable(period_timer_reg) && $stable(WAVEFORM_OUTPUT_O);
  endproperty
  a_sleep_freeze: assert property (p_sleep_freeze)  // RULE10
    else $error("state moved during sleep");

  property p_fall;  // RULE13
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
      (run && !period_start && tb_next == duty_act_reg) |=>
        !WAVEFORM_OUTPUT_O;
  endproperty
  a_fall: assert property (p_fall)  // RULE13
    else $error("output not cleared at duty match");

  property p_disabled_low;  // RULE14
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
      !enable_reg |=> !WAVEFORM_OUTPUT_O && (period_timer_reg == '0);
  endproperty
  a_disabled_low: assert property (p_disabled_low)  // RULE14
    else $error("output or timer active while disabled");

endmodule : pdg_top

// ===== tb/pdg_load_model.sv
// external load model: times each pulse and each period on the pwm pin
module pdg_load_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wave_i,
  output logic [15:0] high_o,
  output logic [15:0] per_o,
  output logic meas_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // pulse timing
  // ----------------------------------------------------------------
  logic prev_reg; // pin level one clock ago
  logic seen_reg; // a rising edge has been met, so a period can close
  logic [15:0] hc_reg; // clocks seen high since the last rise
  logic [15:0] pc_reg; // clocks since the last rise

  // a load only listens: measure rise to rise, report on each rise after the first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_reg <= 1'b0;
      seen_reg <= 1'b0;
      hc_reg <= 16'h0000;
      pc_reg <= 16'h0000;
      meas_o <= 1'b0;
      high_o <= 16'h0000;
      per_o <= 16'h0000;
    end else begin
      prev_reg <= wave_i;
      meas_o <= 1'b0;
      if (wave_i && !prev_reg) begin
        // first rise only starts timing; no full period seen yet
        if (seen_reg) begin
          meas_o <= 1'b1;
          high_o <= hc_reg;
          per_o <= pc_reg;
        end
        seen_reg <= 1'b1;
        hc_reg <= 16'h0001;
        pc_reg <= 16'h0001;
      end else begin
        pc_reg <= pc_reg + 16'h0001;
        if (wave_i) begin
          hc_reg <= hc_reg + 16'h0001;
        end
      end
    end
  end
endmodule : pdg_load_model

// ===== tb/pwm_duty_period_generator_bench.sv
// self-checking bench for the pwm duty/period generator
module pwm_duty_period_generator_bench;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk, rst, hsel, hwrite, sleep, hready, hresp, wave, meas, arm;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, rd_val, v, v2;
  logic [15:0] high_m, per_m;
  logic [31:0] rq[$]; // expected read words, oldest first
  logic [31:0] wq[$]; // expected {high, period} pairs
  int n_errors, checks_done, seed, d;
  event rd_ev;

  pdg_top pdg_top_inst (.CORE_CLK_I(clk), .SYS_RST_I(rst), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(3'b010), .HWDATA_I(hwdata), .HREADY_I(hready),
    .SLEEP_I(sleep), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
    .HRESP_O(hresp), .WAVEFORM_OUTPUT_O(wave));
  pdg_load_model pdg_load_model_inst (.clk_i(clk), .rst_i(rst),
    .wave_i(wave), .high_o(high_m), .per_o(per_m), .meas_o(meas));

  // ----------------------------------------------------------------
  // clock and checking helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  // one ahb-lite single transfer; waits on hready, no fixed latency
  task automatic ahb(input logic [7:0] a, input logic w,
                     input logic [31:0] wd, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] t;
    ahb(a, 1'b1, wd, t);
  endtask : wr

  // read noting the expected word for the monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] t;
    rq.push_back(e);
    ahb(a, 1'b0, 32'h0000_0000, t);
    rd_val = t;
    ->rd_ev;
  endtask : rd

  // ----------------------------------------------------------------
  // monitors: pop the oldest note when a result shows up
  // ----------------------------------------------------------------
  initial forever begin
    @(rd_ev);
    chk(rd_val, rq.pop_front());
  end
  initial forever begin
    @(posedge clk);
    if (meas === 1'b1 && arm && wq.size() > 0) begin
      chk({high_m, per_m}, wq.pop_front());
    end
  end

  // run one setting and time one full period at the load
  task automatic pwm(input int lim, input int ps, input int dt);
    int pf, per;
    pf = 1 << (2 * ps);
    per = (lim + 1) * 4 * pf;
    wr(pdg_pkg::OFS_PERIOD_LIMIT, 32'(lim));
    wr(pdg_pkg::OFS_DUTY_HIGH, 32'(dt >> 2));
    wr(pdg_pkg::OFS_DUTY_LOW, 32'((dt & 3) << 6));
    wr(pdg_pkg::OFS_CTRL, 32'((ps << 1) | 1));
    repeat (2 * per + 8) @(posedge clk);
    wq.push_back({16'(dt * pf), 16'(per)});
    arm <= 1'b1;
    while (wq.size() > 0) @(posedge clk);
    arm <= 1'b0;
    // just past a period start: new duty must wait in the buffer
    wr(pdg_pkg::OFS_DUTY_HIGH, 32'(~dt >> 2) & 32'h0000_00FF);
    ahb(pdg_pkg::OFS_STATUS, 1'b0, 32'h0000_0000, v);
    chk(32'(v[19:10]), 32'(dt));
  endtask : pwm

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, hsel, hwrite, sleep, arm} = 5'b10000;
    haddr = 8'h00;
    htrans = 2'b00;
    hwdata = 32'h0000_0000;
    seed = 56506;
    n_errors = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // response must read okay and the pin low out of reset
    chk(32'({hresp, wave}), 32'h0000_0000);
    // reset values, unmapped hole, read-only status
    rd(pdg_pkg::OFS_CTRL, 32'h0000_0000);
    rd(pdg_pkg::OFS_PERIOD_LIMIT, 32'h0000_00FF);
    rd(pdg_pkg::OFS_DUTY_HIGH, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    wr(pdg_pkg::OFS_STATUS, $random(seed));
    rd(pdg_pkg::OFS_STATUS, 32'h0000_0000);
    v = $random(seed);
    wr(pdg_pkg::OFS_DUTY_HIGH, v);
    rd(pdg_pkg::OFS_DUTY_HIGH, {24'h00_0000, v[7:0]});
    wr(pdg_pkg::OFS_DUTY_LOW, {24'h00_0000, v[7:6], 6'h00});
    rd(pdg_pkg::OFS_DUTY_LOW, {24'h00_0000, v[7:6], 6'h00});
    // every prescale, random duty inside the period
    for (int i = 0; i < 4; i++) begin
      int lim;
      lim = (i == 0) ? 255 : ((i == 1) ? 5 : 3 - i);
      d = 1 + ($unsigned($random(seed)) % (4 * (lim + 1) - 1));
      pwm(lim, i, d);
      wr(pdg_pkg::OFS_CTRL, 32'h0000_0000);
      // the pin drops one edge after the disable lands
      repeat (2) @(posedge clk);
      chk(32'(wave), 32'h0000_0000);
    end
    // edge duties at limit 0: full, beyond, zero, beyond
    wr(pdg_pkg::OFS_PERIOD_LIMIT, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 4 : ((i == 2) ? 0 : 5);
      // low part first: on the step from 5 to 0 the in-between duty is 4, which holds the pin high
      wr(pdg_pkg::OFS_DUTY_LOW, 32'((d & 3) << 6));
      wr(pdg_pkg::OFS_DUTY_HIGH, 32'(d >> 2));
      wr(pdg_pkg::OFS_CTRL, 32'h0000_0001);
      repeat (24) @(posedge clk);
      repeat (40) begin
        @(posedge clk);
        chk(32'(wave), 32'(i < 2));
      end
    end
    // sleep freezes the status word, wake resumes the count
    d = 1 + ($unsigned($random(seed)) % 1023);
    pwm(255, 0, d);
    sleep <= 1'b1;
    repeat (4) @(posedge clk);
    ahb(pdg_pkg::OFS_STATUS, 1'b0, 32'h0000_0000, v);
    chk(32'(v[21]), 32'h0000_0001);
    repeat (50) @(posedge clk);
    rd(pdg_pkg::OFS_STATUS, v);
    sleep <= 1'b0;
    repeat (20) @(posedge clk);
    ahb(pdg_pkg::OFS_STATUS, 1'b0, 32'h0000_0000, v2);
    chk(32'((v2[7:0] - v[7:0]) inside {[8'd1 : 8'd15]}), 32'h1);
    repeat (4) @(posedge clk);
    complete_run();
  end
endmodule : pwm_duty_period_generator_bench
